// ---- rtl/ssp_pkg.sv ----
// Purpose: Shared constants and types for the serial port block.
// Assumes: 10 MHz system clock, 8-bit register port.
// Notes: Register offsets are word indexes on the plain register port.
package ssp_pkg;

   // ==========================================================
   // Register map
   localparam logic [2:0] SSP_ADDR_STATUS = 3'h0;
   localparam logic [2:0] SSP_ADDR_CTRL1 = 3'h1;
   localparam logic [2:0] SSP_ADDR_CTRL3 = 3'h2;
   localparam logic [2:0] SSP_ADDR_BUF = 3'h3;
   localparam logic [2:0] SSP_ADDR_BAUD = 3'h4;
   localparam logic [2:0] SSP_ADDR_IRQ = 3'h5;

   // ==========================================================
   // Field positions
   localparam int SSP_ST_SMP = 7;
   localparam int SSP_ST_CKE = 6;
   localparam int SSP_ST_BF = 0;
   localparam int SSP_C1_WRITE_COLLISION_FLAG = 7;
   localparam int SSP_C1_OV = 6;
   localparam int SSP_C1_EN = 5;
   localparam int SSP_C1_CKP = 4;
   localparam int SSP_C3_BOEN = 4;
   localparam int SSP_IRQ_FLAG = 0;

   // ==========================================================
   // Reset values
   localparam logic [7:0] SSP_RST_BYTE = 8'h00;
   localparam logic [1:0] SSP_RST_STHI = 2'h0;

   // ==========================================================
   // Clock select codes, low nibble of control 1
   localparam logic [3:0] SSP_MODE_DIV4 = 4'h0;
   localparam logic [3:0] SSP_MODE_DIV16 = 4'h1;
   localparam logic [3:0] SSP_MODE_DIV64 = 4'h2;
   localparam logic [3:0] SSP_MODE_TMR = 4'h3;
   localparam logic [3:0] SSP_MODE_SLV_SS = 4'h4;
   localparam logic [3:0] SSP_MODE_SLV = 4'h5;
   localparam logic [3:0] SSP_MODE_BRG = 4'hA;

   // Half bit periods in system clocks for fixed rates
   localparam logic [7:0] SSP_HALF_DIV4 = 8'h02;
   localparam logic [7:0] SSP_HALF_DIV16 = 8'h08;
   localparam logic [7:0] SSP_HALF_DIV64 = 8'h20;
   localparam int SSP_BITS = 8;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {SSP_IDLE, SSP_LEAD, SSP_TRAIL} ssp_state_e;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ssp_bus_s;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic sdo_o;
      logic sdo_oe;
   } ssp_pins_s;

endpackage

// ---- rtl/ssp_shifter.sv ----
// Purpose: Eight-bit exchange register, MSb out first, LSb in.
// Assumes: Strobes are one-cycle pulses from the controller.
// Notes: Load wins over shift in the same cycle; capture still samples.
`timescale 1ns/1ns
module ssp_shifter
#(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic load,
   input wire logic [WIDTH-1:0] load_data,
   input wire logic capture,
   input wire logic sdi,
   input wire logic shift,
   input wire logic clear,
   // Data
   output logic [WIDTH-1:0] data_q,
   output logic out_bit
);
   logic in_q;

   initial
   begin
      if (WIDTH < 2)
         $error("ssp_shifter: WIDTH too small");
   end

   // ==========================================================
   // Sampled input bit, applied on the shift edge
   always_ff @(posedge clk)
   begin
      if (!rst_b || clear)
         in_q <= 1'b0;
      else if (capture)
         in_q <= sdi;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b || clear)
         data_q <= '0;
      else if (load)
         data_q <= load_data;
      // Final shift may meet its own capture: take the pin directly
      else if (shift && capture)
         data_q <= {data_q[WIDTH-2:0], sdi};
      else if (shift)
         data_q <= {data_q[WIDTH-2:0], in_q};
   end

   assign out_bit = data_q[WIDTH-1];
endmodule

// ---- rtl/ssp_spi_port.sv ----
// Purpose: SPI mode of a synchronous serial port, master or slave.
// Assumes: Pins synchronous to clk; slave clock slow against clk.
// Notes: Registers on a plain port, read data one cycle later.
`timescale 1ns/1ns
module ssp_spi_port
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire ssp_pkg::ssp_bus_s bus,
   output logic [7:0] rdata_q,
   // Timer period output pulse
   input wire logic tmr_tick,
   // Serial pins
   input wire logic sck_i,
   input wire logic sdi,
   input wire logic ss_b,
   output ssp_pkg::ssp_pins_s pins,
   // Event flag to the interrupt controller
   output logic port_irq_flag
);
   import ssp_pkg::*;

   logic [1:0] st_hi_q;
   logic buffer_full_flag_q;
   logic [7:0] port_control_reg_1_q;
   logic [7:0] port_control_reg_3_q;
   logic [7:0] serial_data_buffer_q;
   logic [7:0] baud_reload_reg_q;
   logic irq_q;
   ssp_state_e state_q;
   logic [3:0] bit_cnt_q;
   logic [9:0] div_cnt_q;
   logic done_q;
   logic sck_q;
   logic sck_in_q;
   logic [7:0] shift_data;
   logic shift_out;

   logic en, clock_polarity_bit, cke, master, slave_ss, selected;
   logic wr_buf, rd_buf, busy, done;
   logic m_tick, lead_edge, trail_edge;
   logic s_rise, s_fall, s_lead, s_trail;
   logic do_capture, do_shift, do_load, do_clear;
   logic [3:0] mode;

   // Half-period for the divided master clock rates
   // Ten bits, so the largest baud value still fits
   function automatic logic [9:0] half_period(input logic [3:0] m,
      input logic [7:0] baud);
      case (m)
         SSP_MODE_DIV4: half_period = {2'h0, SSP_HALF_DIV4};
         SSP_MODE_DIV16: half_period = {2'h0, SSP_HALF_DIV16};
         SSP_MODE_DIV64: half_period = {2'h0, SSP_HALF_DIV64};
         SSP_MODE_BRG: half_period = {1'h0, baud, 1'h0} + 10'h002;
         default: half_period = {2'h0, SSP_HALF_DIV4};
      endcase
   endfunction

   assign en = port_control_reg_1_q[SSP_C1_EN];
   assign clock_polarity_bit = port_control_reg_1_q[SSP_C1_CKP];
   assign cke = st_hi_q[SSP_ST_CKE-6];
   assign mode = port_control_reg_1_q[3:0];
   assign master = (mode == SSP_MODE_DIV4) || (mode == SSP_MODE_DIV16) ||
      (mode == SSP_MODE_DIV64) || (mode == SSP_MODE_TMR) ||
      (mode == SSP_MODE_BRG);
   assign slave_ss = (mode == SSP_MODE_SLV_SS);
   assign selected = !slave_ss || !ss_b;
   assign wr_buf = bus.wr && (bus.addr == SSP_ADDR_BUF);
   assign rd_buf = bus.rd && (bus.addr == SSP_ADDR_BUF);
   assign busy = (state_q != SSP_IDLE);

   // ==========================================================
   // Register writes
   // control 1 fully read/write
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         port_control_reg_1_q <= SSP_RST_BYTE;
      else
      begin
         if (bus.wr && bus.addr == SSP_ADDR_CTRL1)
            port_control_reg_1_q <= bus.wdata;
         // collision sets, set wins over clear
         if (wr_buf && (busy || done_q))
            port_control_reg_1_q[SSP_C1_WRITE_COLLISION_FLAG] <= 1'b1;
         if (done_q && buffer_full_flag_q && !rd_buf)
            port_control_reg_1_q[SSP_C1_OV] <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         st_hi_q <= SSP_RST_STHI;
         port_control_reg_3_q <= SSP_RST_BYTE;
         baud_reload_reg_q <= SSP_RST_BYTE;
      end
      else if (bus.wr)
      begin
         // only the upper two status bits take writes
         if (bus.addr == SSP_ADDR_STATUS)
            st_hi_q <= bus.wdata[SSP_ST_SMP:SSP_ST_CKE];
         if (bus.addr == SSP_ADDR_CTRL3)
            port_control_reg_3_q <= bus.wdata;
         if (bus.addr == SSP_ADDR_BAUD)
            baud_reload_reg_q <= bus.wdata;
      end
   end

   // ==========================================================
   // Data buffer and status flags
   // write accepted only when idle and no collision
   assign do_load = wr_buf && !busy && !done_q && en &&
      !port_control_reg_1_q[SSP_C1_WRITE_COLLISION_FLAG];

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         serial_data_buffer_q <= SSP_RST_BYTE;
      else if (do_load)
         serial_data_buffer_q <= bus.wdata;
      else if (done_q && (!buffer_full_flag_q ||
         port_control_reg_3_q[SSP_C3_BOEN]))
         serial_data_buffer_q <= shift_data;
   end

   // full on receive, cleared by buffer read, set wins
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         buffer_full_flag_q <= 1'b0;
      else if (done_q)
         buffer_full_flag_q <= 1'b1;
      else if (rd_buf)
         buffer_full_flag_q <= 1'b0;
   end

   // interrupt flag, cleared by writing zero, set wins
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         irq_q <= 1'b0;
      else if (done_q)
         irq_q <= 1'b1;
      else if (bus.wr && bus.addr == SSP_ADDR_IRQ)
         irq_q <= bus.wdata[SSP_IRQ_FLAG];
   end
   assign port_irq_flag = irq_q;

   // ==========================================================
   // Read data, one cycle after the strobe
   // shift register has no address of its own
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         rdata_q <= SSP_RST_BYTE;
      else if (bus.rd)
         case (bus.addr)
            SSP_ADDR_STATUS: rdata_q <= {st_hi_q, 5'h00, buffer_full_flag_q};
            SSP_ADDR_CTRL1: rdata_q <= port_control_reg_1_q;
            SSP_ADDR_CTRL3: rdata_q <= port_control_reg_3_q;
            SSP_ADDR_BUF: rdata_q <= serial_data_buffer_q;
            SSP_ADDR_BAUD: rdata_q <= baud_reload_reg_q;
            SSP_ADDR_IRQ: rdata_q <= {7'h00, irq_q};
            default: rdata_q <= 8'h00;
         endcase
      else
         rdata_q <= 8'h00;
   end

   // ==========================================================
   // Master clock generator
   // divider or one timer tick period sets the half period
   always_ff @(posedge clk)
   begin
      if (!rst_b || !busy || !master || mode == SSP_MODE_TMR)
         div_cnt_q <= 10'h000;
      else if (div_cnt_q == half_period(mode, baud_reload_reg_q) - 10'h001)
         div_cnt_q <= 10'h000;
      else
         div_cnt_q <= div_cnt_q + 10'h001;
   end

   assign m_tick = master && busy && ((mode == SSP_MODE_TMR) ? tmr_tick :
      (div_cnt_q == half_period(mode, baud_reload_reg_q) - 10'h001));

   // Slave clock edges, pin taken as synchronous
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         sck_in_q <= 1'b0;
      else
         sck_in_q <= sck_i;
   end
   assign s_rise = sck_i && !sck_in_q;
   assign s_fall = !sck_i && sck_in_q;
   // Leading edge leaves the idle level
   assign s_lead = !master && en && selected && (clock_polarity_bit ? s_fall : s_rise);
   assign s_trail = !master && en && selected && (clock_polarity_bit ? s_rise : s_fall);

   // ==========================================================
   // Exchange sequencer
   // CKE=1 shifts on trailing edges, data ready before lead
   assign lead_edge = master ? (m_tick && state_q == SSP_LEAD) : s_lead;
   assign trail_edge = master ? (m_tick && state_q == SSP_TRAIL) : s_trail;
   assign do_capture = cke ? lead_edge : trail_edge;
   assign do_shift = (cke ? trail_edge : lead_edge) &&
      !(cke == 1'b0 && bit_cnt_q == 4'h0);
   assign done = trail_edge && bit_cnt_q == 4'(SSP_BITS - 1);
   // disabling resets the machine; deselect resets slave
   assign do_clear = !en || (!master && slave_ss && ss_b);

   // Last shift lands on the done edge, so the byte is taken a cycle later
   always_ff @(posedge clk)
   begin
      if (!rst_b || do_clear)
         done_q <= 1'b0;
      else
         done_q <= done;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b || do_clear)
      begin
         state_q <= SSP_IDLE;
         bit_cnt_q <= 4'h0;
      end
      else
         case (state_q)
            SSP_IDLE:
            begin
               // master starts clocking on buffer write
               if (do_load && master)
                  state_q <= SSP_LEAD;
               else if (s_lead)
                  state_q <= SSP_TRAIL;
            end
            SSP_LEAD:
               if (lead_edge)
                  state_q <= SSP_TRAIL;
            SSP_TRAIL:
               if (done)
               begin
                  // clock stops after the last bit
                  state_q <= SSP_IDLE;
                  bit_cnt_q <= 4'h0;
               end
               else if (trail_edge)
               begin
                  state_q <= SSP_LEAD;
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
               else if (!master && s_lead)
                  state_q <= SSP_TRAIL;
            default:
               state_q <= SSP_IDLE;
         endcase
   end

   // master clock rests at polarity level
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         sck_q <= 1'b0;
      else if (!busy || !master)
         sck_q <= clock_polarity_bit;
      else if (m_tick)
         sck_q <= !sck_q;
   end

   ssp_shifter #(
      .WIDTH(SSP_BITS)
   ) u_shift (
      .clk(clk),
      .rst_b(rst_b),
      .load(do_load),
      .load_data(bus.wdata),
      .capture(do_capture),
      // our input comes from partner output
      .sdi(sdi),
      .shift(do_shift || (done && !cke)),
      .clear(!en),
      .data_q(shift_data),
      .out_bit(shift_out)
   );

   // ==========================================================
   // Pin drive
   // pins released while disabled; unselected drives nothing
   assign pins.sck_o = sck_q;
   assign pins.sck_oe = en && master;
   assign pins.sdo_o = shift_out;
   assign pins.sdo_oe = en && (master || !slave_ss || !ss_b);
endmodule

// ---- verification/ssp_checker.sv ----
// Purpose: Port assertions for the SPI port.
// Assumes: Control 1 enable, polarity and mode fields change only through bus writes.
// Notes: Helpers mirror control 1 and count clock toggles.
`timescale 1ns/1ns
module ssp_checker
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Watched ports
   input wire ssp_pkg::ssp_bus_s bus,
   input wire logic [7:0] rdata_q,
   input wire logic tmr_tick,
   input wire logic sck_i,
   input wire logic sdi,
   input wire logic ss_b,
   input wire ssp_pkg::ssp_pins_s pins,
   input wire logic port_irq_flag
);
   import ssp_pkg::*;
   // ==========================
   // Helpers
   logic rd_q;
   logic [7:0] c1_q;
   logic [4:0] tg_q;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         rd_q <= 1'b0;
         c1_q <= 8'h00;
         tg_q <= 5'h00;
      end
      else
      begin
         rd_q <= bus.rd;
         if (bus.wr && bus.addr == SSP_ADDR_CTRL1)
            c1_q <= bus.wdata;
         // Restart count on any write to the interrupt flag
         if (bus.wr && bus.addr == SSP_ADDR_IRQ)
            tg_q <= 5'h00;
         else if ($changed(pins.sck_o))
            tg_q <= tg_q + 5'h01;
      end
   end
   // ==========================
   // Assertions
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence hi_two;
      pins.sck_o [*2] ##1 !pins.sck_o;
   endsequence
   sequence at_idle;
      tg_q == 5'h10 && pins.sck_o == c1_q[SSP_C1_CKP];
   endsequence
   rdata_idle_zero_a: assert property (
      !rd_q |-> rdata_q == 8'h00) else $error("stray read data");
   irq_hold_a: assert property (
      port_irq_flag && !(bus.wr && bus.addr == SSP_ADDR_IRQ)
      |=> port_irq_flag) else $error("irq flag dropped");
   pins_off_a: assert property (
      !c1_q[SSP_C1_EN] && $stable(c1_q) |-> !pins.sck_oe && !pins.sdo_oe)
      else $error("pins driven while disabled");
   idle_level_a: assert property (
      c1_q[3:0] != SSP_MODE_SLV_SS && c1_q[3:0] != SSP_MODE_SLV
      && $rose(port_irq_flag) |-> ##[0:70] at_idle)
      else $error("clock not idle after byte");
   edge_count_a: assert property (
      tg_q == 5'h10 && !bus.wr |=> tg_q <= 5'h10)
      else $error("clock runs past byte");
   slave_quiet_a: assert property (
      c1_q[SSP_C1_EN] && c1_q[3:0] == SSP_MODE_SLV_SS && $stable(c1_q)
      && ss_b && $past(ss_b) |-> !pins.sdo_oe) else $error("slave drives");
   master_drive_a: assert property (
      c1_q[SSP_C1_EN] && c1_q[3:0] == SSP_MODE_DIV4 && $stable(c1_q)
      |-> pins.sck_oe && pins.sdo_oe) else $error("master pins off");
   half_div4_a: assert property (
      c1_q[SSP_C1_EN] && c1_q[3:0] == SSP_MODE_DIV4
      && $rose(pins.sck_o) |-> hi_two) else $error("bad half period");
endmodule

bind ssp_spi_port ssp_checker chk (.clk(clk), .rst_b(rst_b), .bus(bus),
   .rdata_q(rdata_q), .tmr_tick(tmr_tick), .sck_i(sck_i), .sdi(sdi),
   .ss_b(ss_b), .pins(pins), .port_irq_flag(port_irq_flag));

// ---- verification/ssp_slave_model.sv ----
// Purpose: Behavioural SPI slave at the far end.
// Assumes: Idle-low clock; out on falling, sample on rising.
// Notes: Released data line shows the inverse of its last bit.
`timescale 1ns/1ns
module ssp_slave_model
(
   // Serial side
   input wire logic sck,
   input wire logic sel_b,
   input wire logic din,
   output logic dout,
   // Bench side
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   logic bit_q;
   initial rx_byte = 8'h00;
   assign dout = sel_b ? ~rx_byte[7] : rx_byte[7];
   always @(negedge sel_b)
      rx_byte = tx_byte;
   always @(posedge sck)
      if (!sel_b)
         bit_q = din;
   always @(negedge sck)
      if (!sel_b)
         rx_byte = {rx_byte[6:0], bit_q};
endmodule

// ---- verification/ssp_spi_port_tb.sv ----
// Purpose: Self-checking bench for the SPI port.
// Assumes: Master runs use idle-low clock, output on falling edge.
// Notes: Timer tick every three clocks for the timer option.
`timescale 1ns/1ns
module ssp_spi_port_tb;
   import ssp_pkg::*;
   typedef struct packed {logic [2:0] a; logic [7:0] w, e;} ssp_row_s;
   typedef struct packed {logic [3:0] m; logic [7:0] tx, sv, h;} ssp_xf_s;
   logic clk, rst_b, tmr_tick, sck_t, ss_t, sel_b, miso, irq, m_sdo;
   logic [7:0] rdata_q, s_tx, s_rx;
   ssp_bus_s bus;
   ssp_pins_s pins;
   int err_total, num_checks, cyc, i;
   ssp_row_s rows [5];
   ssp_xf_s xfs [5];
   ssp_spi_port uut (.clk(clk), .rst_b(rst_b), .bus(bus),
      .rdata_q(rdata_q), .tmr_tick(tmr_tick), .sck_i(sck_t),
      .sdi(sel_b ? m_sdo : miso), .ss_b(ss_t), .pins(pins),
      .port_irq_flag(irq));
   ssp_slave_model far (.sck(pins.sck_o), .sel_b(sel_b),
      .din(pins.sdo_o), .dout(miso), .tx_byte(s_tx), .rx_byte(s_rx));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      tmr_tick <= (cyc % 3 == 2);
      if (cyc == 20000)
      begin
         err_total++;
         test_done();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk(rdata_q, e);
   endtask
   task automatic xfer(input ssp_xf_s x, input logic col);
      int k;
      wr(SSP_ADDR_CTRL1, {4'h2, x.m});
      s_tx = x.sv;
      sel_b <= 1'b0;
      wr(SSP_ADDR_BUF, x.tx);
      if (col)
         wr(SSP_ADDR_BUF, ~x.tx);
      for (k = 0; !pins.sck_o && k < 200; k++)
         @(posedge clk);
      for (k = 0; pins.sck_o && k < 200; k++)
         @(posedge clk);
      for (k = 0; !pins.sck_o && k < 200; k++)
         @(posedge clk);
      chk(8'(k), x.h);
      for (k = 0; !irq && k < 2000; k++)
         @(posedge clk);
      chk({7'h00, irq}, 8'h01);
      repeat (x.h + 2) @(posedge clk);
      sel_b <= 1'b1;
      chk(s_rx, x.tx);
      rdc(SSP_ADDR_STATUS, 8'h41);
      rdc(SSP_ADDR_BUF, x.sv);
      rdc(SSP_ADDR_STATUS, 8'h40);
      rdc(SSP_ADDR_CTRL1, {col, 3'h2, x.m});
      rdc(SSP_ADDR_IRQ, 8'h01);
      wr(SSP_ADDR_CTRL1, {4'h2, x.m});
      wr(SSP_ADDR_IRQ, 8'h00);
      $display("exchange done, mode %h", x.m);
   endtask
   // Bench acts as master: idle-low clock, samples on rising edge
   task automatic slv(input logic [3:0] m, input logic ss,
      input logic [7:0] tx, input logic [7:0] mb);
      logic [7:0] got;
      int j;
      wr(SSP_ADDR_CTRL1, {4'h2, m});
      ss_t <= ss;
      wr(SSP_ADDR_BUF, tx);
      for (j = 7; j >= 0; j--)
      begin
         m_sdo <= mb[j];
         repeat (3) @(posedge clk);
         sck_t <= 1'b1;
         got[j] = pins.sdo_o;
         repeat (3) @(posedge clk);
         sck_t <= 1'b0;
         chk({7'h00, pins.sdo_oe}, 8'h01);
      end
      repeat (4) @(posedge clk);
      chk(got, tx);
      chk({7'h00, irq}, 8'h01);
      rdc(SSP_ADDR_BUF, mb);
      rdc(SSP_ADDR_STATUS, 8'h40);
      wr(SSP_ADDR_IRQ, 8'h00);
      $display("slave exchange done, mode %h", m);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================
   // Stimulus
   initial
   begin
      rst_b = 1'b0;
      bus = '0;
      tmr_tick = 1'b0;
      sck_t = 1'b0;
      ss_t = 1'b1;
      sel_b = 1'b1;
      m_sdo = 1'b0;
      s_tx = 8'h00;
      cyc = 0;
      err_total = 0;
      num_checks = 0;
      rows = '{'{SSP_ADDR_STATUS, 8'hFF, 8'hC0}, '{SSP_ADDR_CTRL1, 8'h5A,
         8'h5A}, '{SSP_ADDR_BAUD, 8'h5A, 8'h5A}, '{SSP_ADDR_CTRL3, 8'h10,
         8'h10}, '{3'h6, 8'hFF, 8'h00}};
      xfs = '{'{SSP_MODE_DIV4, 8'hA5, 8'h5A, 8'h02}, '{SSP_MODE_DIV16,
         8'h3C, 8'hE1, 8'h08}, '{SSP_MODE_DIV64, 8'h81, 8'h18, 8'h20},
         '{SSP_MODE_TMR, 8'h7E, 8'h96, 8'h03}, '{SSP_MODE_BRG, 8'hC3,
         8'h0F, 8'h04}};
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      for (i = 0; i < 5; i++)
      begin
         wr(rows[i].a, rows[i].w);
         rdc(rows[i].a, rows[i].e);
      end
      $display("register table done");
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rdc(SSP_ADDR_CTRL1, 8'h00);
      chk({6'h00, pins.sck_oe, pins.sdo_oe}, 8'h00);
      wr(SSP_ADDR_BUF, 8'h55);
      repeat (40) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      rdc(SSP_ADDR_BUF, 8'h00);
      $display("disabled port done");
      wr(SSP_ADDR_STATUS, 8'h40);
      wr(SSP_ADDR_BAUD, 8'h01);
      for (i = 0; i < 5; i++)
         xfer(xfs[i], 1'b0);
      xfer('{SSP_MODE_DIV16, 8'h99, 8'h66, 8'h08}, 1'b1);
      wr(SSP_ADDR_CTRL1, {4'h2, SSP_MODE_SLV_SS});
      repeat (16)
      begin
         repeat (3) @(posedge clk);
         sck_t <= ~sck_t;
      end
      repeat (3) @(posedge clk);
      chk({7'h00, pins.sdo_oe}, 8'h00);
      chk({7'h00, irq}, 8'h00);
      rdc(SSP_ADDR_STATUS, 8'h40);
      $display("unselected slave done");
      slv(SSP_MODE_SLV_SS, 1'b0, 8'hB4, 8'h6D);
      slv(SSP_MODE_SLV, 1'b1, 8'h2B, 8'hD2);
      test_done();
   end
endmodule
